// ==== rtl/csq_qualifier.sv ====
/*
 chip-select option qualifier: option and match registers, per-select qualification, strobe
 timing, internal transfer acknowledge with wait states, e clock timing and interrupt acknowledge.
 assumes of its surroundings:
 - the bus master holds cycle_in stable from cycle_start_in until the cycle ends;
 - cycle_end_in follows the acknowledge, autovector or external acknowledge, and always
   comes before the next cycle_start_in;
 - address and data strobes come from pins and are synchronised here, so an
   asynchronous select trails its strobe by three clock edges;
 - a select rises at the edge that takes cycle_end_in, whatever the strobes still show;
 - register strobes are one cycle long and never both high at once;
 - read data stand only in the cycle after the read strobe and read zero otherwise;
 - unmapped indices read zero and ignore writes; the status word reads status and ignores writes;
 - an 8-bit port ignores the byte-lane field;
 - a cpu-space select answers interrupt acknowledge cycles and ignores the address range;
 - a synchronous select never acknowledges internally, it waits for the master to end;
 - when several latched selects give acknowledge codes, the highest index sets the timing;
 - an external acknowledge code leaves the cycle to the selected device.
*/
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - mode 0 times select from bus strobes; mode 1 asserts with e clock
// - asynchronous only: strobe select 0 aligns to address strobe, 1 to data strobe
// - byte lanes: 00 off, 01 lower, 10 upper, 11 both
// - direction: 00 off, 01 reads, 10 writes, 11 both
// - ack codes 0000..1101 give internal acknowledge after 3 plus code cycles
// - ack code 1110 ends the access in two cycles
// - ack code 1111 leaves acknowledge to the external device
// - space: 00 cpu, 01 user, 10 supervisor, 11 supervisor or user
// - cpu space: compare address 3..1 with priority field on interrupt acknowledge
// - priority field 000 matches any level, else only that level
// - all option registers share layout; boot resets 7B70, others zero
// - interrupt acknowledge with autovector raises autovector and ends the cycle
// - address match compares only upper bits selected by block size
module csq_qualifier
   import csq_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [15:0] reg_rdata_out,
   input wire logic [NUM_CS-1:0] port16_in,
   input wire logic cycle_start_in,
   input wire logic cycle_end_in,
   input wire csq_cycle_t cycle_in,
   input wire logic address_strobe_n_in,
   input wire logic data_strobe_n_in,
   output logic [NUM_CS-1:0] select_n_out,
   output logic transfer_ack_out,
   output logic auto_vector_out,
   output logic e_bus_clock_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage

   logic [15:0] opt_reg [NUM_CS];
   logic [15:0] base_reg [NUM_CS];
   logic [NUM_CS-1:0] hit;
   logic [NUM_CS-1:0] qualified;
   logic [NUM_CS-1:0] latched;
   logic [NUM_CS-1:0] next_select_n;
   logic as_meta, as_sync, ds_meta, ds_sync;
   logic e_rise, e_level;
   logic in_cycle;
   logic [4:0] cycle_count;
   logic ack_done;
   logic [15:0] status;

   function automatic csq_opt_t unpack_opt(input logic [15:0] raw);
      unpack_opt = csq_opt_t'(raw);
   endfunction : unpack_opt

   function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] base,
                                    input int idx);
      reg_hit = (addr == base + 5'(idx));
   endfunction : reg_hit

   // lanes qualify only a 16-bit port; an 8-bit port ignores the field
   function automatic logic lanes_pass(input csq_opt_t o, input logic port16, input csq_cycle_t c);
      logic ok;
      ok = 1'b1;
      if (port16) begin
         case (o.byte_lanes)
            2'h0: ok = 1'b0;
            2'h1: ok = c.lower_byte;
            2'h2: ok = c.upper_byte;
            default: ok = 1'b1;
         endcase
      end
      return ok;
   endfunction : lanes_pass

   function automatic logic dir_pass(input csq_opt_t o, input csq_cycle_t c);
      logic ok;
      case (o.dir)
         2'h0: ok = 1'b0;
         2'h1: ok = c.read;
         2'h2: ok = !c.read;
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction : dir_pass

   // cpu space answers only interrupt acknowledge at a matching level; zero matches any level
   function automatic logic space_pass(input csq_opt_t o, input csq_cycle_t c);
      logic level_ok, user, supv;
      logic ok;
      level_ok = (o.irq_level_match == 3'h0) || (o.irq_level_match == c.addr[3:1]);
      user = !c.iack && c.fc_space == SPACE_USER;
      supv = !c.iack && c.fc_space == SPACE_SUPV;
      case (o.space)
         SPACE_CPU: ok = c.iack && level_ok;
         SPACE_USER: ok = user;
         SPACE_SUPV: ok = supv;
         default: ok = user || supv;
      endcase
      return ok;
   endfunction : space_pass

   ////////////////////////////////////////////////////////////////////////////////
   // register writes
   // an unmapped index matches no register, so its write is dropped

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CS; gi++) begin : g_regs
         always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
               opt_reg[gi] <= (gi == 0) ? BOOT_OPT_RESET : GEN_OPT_RESET;
               base_reg[gi] <= (gi == 0) ? BOOT_BASE_RESET : GEN_BASE_RESET;
            end else if (reg_write_in) begin
               if (reg_hit(reg_addr_in, ADDR_OPT_BASE, gi)) begin
                  opt_reg[gi] <= reg_wdata_in;
               end
               if (reg_hit(reg_addr_in, ADDR_BASE_BASE, gi)) begin
                  base_reg[gi] <= reg_wdata_in;
               end
            end
         end

         csq_match u_match (
            .addr_in(cycle_in.addr),
            .base_in(base_reg[gi]),
            .hit_out(hit[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // register reads: data the cycle after the strobe

   always_comb begin
      status = {8'h00, 3'h0, in_cycle, ack_done, auto_vector_out, transfer_ack_out, e_level};
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_read_in) begin
         reg_rdata_out <= 16'h0000;
         for (int i = 0; i < NUM_CS; i++) begin
            if (reg_hit(reg_addr_in, ADDR_OPT_BASE, i)) begin
               reg_rdata_out <= opt_reg[i];
            end
            if (reg_hit(reg_addr_in, ADDR_BASE_BASE, i)) begin
               reg_rdata_out <= base_reg[i];
            end
         end
         if (reg_addr_in == ADDR_STATUS) begin
            reg_rdata_out <= status;
         end
      end else begin
         reg_rdata_out <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // strobe synchronisers and e clock
   // strobes idle high, so the synchronisers reset high and no false select follows reset

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         as_meta <= 1'b1;
         as_sync <= 1'b1;
         ds_meta <= 1'b1;
         ds_sync <= 1'b1;
      end else begin
         as_meta <= address_strobe_n_in;
         as_sync <= as_meta;
         ds_meta <= data_strobe_n_in;
         ds_sync <= ds_meta;
      end
   end

   csq_e_clock u_e_bus_clock (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .e_rise_out(e_rise),
      .e_bus_clock_out(e_level)
   );

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         e_bus_clock_out <= 1'b0;
      end else begin
         e_bus_clock_out <= e_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // qualification per select

   generate
      for (gi = 0; gi < NUM_CS; gi++) begin : g_qual
         csq_opt_t o;
         logic lanes_ok, dir_ok, space_ok;
         always_comb begin
            o = unpack_opt(opt_reg[gi]);
            lanes_ok = lanes_pass(o, port16_in[gi], cycle_in);
            dir_ok = dir_pass(o, cycle_in);
            space_ok = space_pass(o, cycle_in);
            // cpu-space select does not decode the address range
            qualified[gi] = (hit[gi] || o.space == SPACE_CPU) && space_ok && dir_ok && lanes_ok;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // cycle tracking and select timing

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         in_cycle <= 1'b0;
         latched <= '0;
      end else if (cycle_end_in) begin
         in_cycle <= 1'b0;
         latched <= '0;
      end else if (cycle_start_in) begin
         in_cycle <= 1'b1;
         latched <= qualified;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CS; i++) begin
         csq_opt_t oc;
         oc = unpack_opt(opt_reg[i]);
         next_select_n[i] = 1'b1;
         // the edge that takes cycle_end_in releases the select at once
         if (latched[i] && in_cycle && !cycle_end_in) begin
            // a synchronous select falls at the next e clock rise and holds low to the end
            if (oc.mode) begin
               next_select_n[i] = select_n_out[i] && !e_rise ? 1'b1 : 1'b0;
            end else if (oc.strobe_alignment_select) begin
               next_select_n[i] = ds_sync;
            end else begin
               next_select_n[i] = as_sync;
            end
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         select_n_out <= '1;
      end else begin
         select_n_out <= next_select_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // internal acknowledge and autovector

   logic [4:0] ack_target;
   logic ack_internal;
   logic want_auto_vector_enable;
   always_comb begin
      ack_target = ACK_BASE_CYCLES;
      ack_internal = 1'b0;
      want_auto_vector_enable = 1'b0;
      for (int i = 0; i < NUM_CS; i++) begin
         csq_opt_t oa;
         oa = unpack_opt(opt_reg[i]);
         if (latched[i] && !oa.mode) begin
            if (oa.transfer_ack_select == ACK_FAST) begin
               ack_target = ACK_FAST_CYCLES;
               ack_internal = 1'b1;
            end else if (oa.transfer_ack_select != ACK_EXT) begin
               ack_target = ACK_BASE_CYCLES + {1'b0, oa.transfer_ack_select};
               ack_internal = 1'b1;
            end // external code leaves ack to the device
         end
         if (latched[i] && oa.space == SPACE_CPU && oa.auto_vector_enable) begin
            want_auto_vector_enable = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      // saturates, so a long external cycle cannot wrap into a false acknowledge
      if (reset_in) begin
         cycle_count <= 5'h00;
      end else if (cycle_start_in) begin
         cycle_count <= 5'h01;
      end else if (in_cycle && !ack_done && cycle_count != 5'h1F) begin
         cycle_count <= cycle_count + 5'h01;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         transfer_ack_out <= 1'b0;
         auto_vector_out <= 1'b0;
         ack_done <= 1'b0;
      end else if (cycle_start_in || cycle_end_in) begin
         transfer_ack_out <= 1'b0;
         auto_vector_out <= 1'b0;
         ack_done <= 1'b0;
      end else if (in_cycle && !ack_done && cycle_count == ack_target - 5'h01) begin
         // autovector replaces the acknowledge, so at most one of them pulses per cycle
         if (want_auto_vector_enable) begin
            auto_vector_out <= 1'b1;
            ack_done <= 1'b1;
         end else if (ack_internal) begin
            transfer_ack_out <= 1'b1;
            ack_done <= 1'b1;
         end
      end else begin
         transfer_ack_out <= 1'b0;
         auto_vector_out <= 1'b0;
      end
   end

endmodule : csq_qualifier
`default_nettype wire

// ==== rtl/csq_pkg.sv ====
/*
 chip-select option qualifier package: register layout, reset values, field codes, timing counts.
 assumes nothing beyond a SystemVerilog compiler.
*/
package csq_pkg;

   localparam int NUM_CS = 12;          // index 0 is the boot select, 1..11 the general selects
   localparam int CS_IDX_W = 4;

   // register port addresses (word index)
   localparam logic [4:0] ADDR_OPT_BASE = 5'h00;  // 0x00..0x0B option registers, 0 = boot
   localparam logic [4:0] ADDR_BASE_BASE = 5'h10; // 0x10..0x1B match base/size registers
   localparam logic [4:0] ADDR_STATUS = 5'h1F;

   localparam logic [15:0] BOOT_OPT_RESET = 16'h7B70;
   localparam logic [15:0] GEN_OPT_RESET = 16'h0000;
   localparam logic [15:0] BOOT_BASE_RESET = 16'h0007;
   localparam logic [15:0] GEN_BASE_RESET = 16'h0000;

   // option field positions
   localparam int F_MODE = 15;
   localparam int F_BYTE = 13;
   localparam int F_DIR = 11;
   localparam int F_STROBE_ALIGNMENT_SELECT = 10;
   localparam int F_ACK = 6;
   localparam int F_SPACE = 4;
   localparam int F_IPL = 1;
   localparam int F_AUTO_VECTOR_ENABLE = 0;

   localparam logic [3:0] ACK_FAST = 4'hE;
   localparam logic [3:0] ACK_EXT = 4'hF;
   localparam logic [4:0] ACK_BASE_CYCLES = 5'h03;
   localparam logic [4:0] ACK_FAST_CYCLES = 5'h02;

   localparam logic [1:0] SPACE_CPU = 2'h0;
   localparam logic [1:0] SPACE_USER = 2'h1;
   localparam logic [1:0] SPACE_SUPV = 2'h2;
   localparam logic [1:0] SPACE_BOTH = 2'h3;

   // e clock: divide 50 MHz system clock by this count
   localparam logic [3:0] E_DIV = 4'h8;

   typedef struct packed {
      logic mode;
      logic [1:0] byte_lanes;
      logic [1:0] dir;
      logic strobe_alignment_select;
      logic [3:0] transfer_ack_select;
      logic [1:0] space;
      logic [2:0] irq_level_match;
      logic auto_vector_enable;
   } csq_opt_t;

   // one bus cycle as the master presents it
   typedef struct packed {
      logic [23:0] addr;
      logic read;
      logic [1:0] fc_space;   // 00 cpu, 01 user, 10 supervisor
      logic iack;
      logic upper_byte;
      logic lower_byte;
   } csq_cycle_t;

endpackage : csq_pkg

// ==== rtl/csq_e_clock.sv ====
/*
 e clock divider: one-cycle enable at the e clock rise and a registered e clock level.
 assumes a single system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module csq_e_clock
   import csq_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   output logic e_rise_out,
   output logic e_bus_clock_out
);

   logic [3:0] count;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         count <= 4'h0;
      end else if (count == E_DIV - 4'h1) begin
         count <= 4'h0;
      end else begin
         count <= count + 4'h1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         e_rise_out <= 1'b0;
         e_bus_clock_out <= 1'b0;
      end else begin
         e_rise_out <= (count == E_DIV - 4'h1);
         if (count == E_DIV - 4'h1) begin
            e_bus_clock_out <= 1'b1;
         end else if (count == (E_DIV >> 1) - 4'h1) begin
            e_bus_clock_out <= 1'b0;
         end
      end
   end

endmodule : csq_e_clock
`default_nettype wire

// ==== rtl/csq_match.sv ====
/*
 address match for one select: compares the upper address bits chosen by the block size.
 assumes a 24-bit address and the base register layout addr[23:11] in bits 15:3.
*/
`timescale 1ns/100ps
`default_nettype none
module csq_match
   import csq_pkg::*;
(
   input wire logic [23:0] addr_in,
   input wire logic [15:0] base_in,
   output logic hit_out
);

   logic [12:0] mask;

   always_comb begin
      case (base_in[2:0])
         3'h0: mask = 13'h1FFF;
         3'h1: mask = 13'h1FFC;
         3'h2: mask = 13'h1FF8;
         3'h3: mask = 13'h1FE0;
         3'h4: mask = 13'h1FC0;
         3'h5: mask = 13'h1F80;
         3'h6: mask = 13'h1F00;
         default: mask = 13'h1E00;
      endcase
      hit_out = ((addr_in[23:11] ^ base_in[15:3]) & mask) == 13'h0000;
   end

endmodule : csq_match
`default_nettype wire

// ==== dv/csq_checker.sv ====
/*
 checker for the chip-select option qualifier: port-level timing relations.
 assumes it is bound into csq_qualifier and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module csq_checker
   import csq_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic reg_read_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic cycle_start_in,
   input wire logic cycle_end_in,
   input wire logic [NUM_CS-1:0] select_n_out,
   input wire logic transfer_ack_out,
   input wire logic auto_vector_out,
   input wire logic e_bus_clock_out
);
   logic in_cyc;
   ////////////////////////////////////////
   // tracks whether a bus cycle is open
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         in_cyc <= 1'b0;
      else if (cycle_start_in)
         in_cyc <= 1'b1;
      else if (cycle_end_in)
         in_cyc <= 1'b0;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   a_e_clock_period: assert property ($rose(e_bus_clock_out) |=>
      (!$rose(e_bus_clock_out))[*7] ##1 $rose(e_bus_clock_out)) else $error("e clock period wrong");
   a_ack_one_cycle: assert property (transfer_ack_out |=> !transfer_ack_out)
      else $error("acknowledge longer than one cycle");
   a_ack_in_cycle: assert property (transfer_ack_out |-> in_cyc)
      else $error("acknowledge outside a bus cycle");
   a_auto_vector_enable_one_cycle: assert property (auto_vector_out |=> !auto_vector_out)
      else $error("autovector longer than one cycle");
   a_auto_vector_enable_not_ack: assert property (!(auto_vector_out && transfer_ack_out))
      else $error("autovector and acknowledge together");
   a_end_clears_sel: assert property (cycle_end_in |=> &select_n_out)
      else $error("select held after cycle end");
   a_sel_idle_high: assert property (!in_cyc && !$past(in_cyc) |-> &select_n_out)
      else $error("select outside a bus cycle");
   a_rdata_idle_zero: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data without a read");
endmodule : csq_checker
bind csq_qualifier csq_checker u_chk (.clk_in(clk_in), .reset_in(reset_in), .reg_read_in(reg_read_in),
   .reg_rdata_out(reg_rdata_out), .cycle_start_in(cycle_start_in), .cycle_end_in(cycle_end_in),
   .select_n_out(select_n_out), .transfer_ack_out(transfer_ack_out),
   .auto_vector_out(auto_vector_out), .e_bus_clock_out(e_bus_clock_out));
`default_nettype wire

// ==== dv/csq_ext_dev.sv ====
/*
 external device on one select line: notes selection, gives its own acknowledge.
 assumes select is active low and clr_in pulses at each cycle start.
*/
`timescale 1ns/100ps
`default_nettype none
module csq_ext_dev (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sel_n_in,
   input wire logic clr_in,
   output logic hit_out,
   output logic ack_out
);
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         hit_out <= 1'b0;
      else if (clr_in)
         hit_out <= 1'b0;
      else if (!sel_n_in)
         hit_out <= 1'b1;
   end
   // own acknowledge on the first selected cycle
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         ack_out <= 1'b0;
      else
         ack_out <= !sel_n_in && !hit_out;
   end
endmodule : csq_ext_dev
`default_nettype wire

// ==== dv/tb_csq_qualifier.sv ====
/*
 testbench for csq_qualifier: registers, qualifiers, acknowledge timing.
 assumes only select 1 is programmed; select 0 keeps its boot reset value and the others stay disabled.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_csq_qualifier
   import csq_pkg::*;
;
   logic clk_in = 1'b0, reset_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
   logic st = 1'b0, en = 1'b0, as_n = 1'b1, ds_n = 1'b1;
   logic [4:0] ra = 5'h00;
   logic [15:0] wd = 16'h0000, rv, rdata;
   logic [NUM_CS-1:0] p16 = '0, sel_n;
   csq_cycle_t cv = '0;
   logic ack, av, e_bus_clock, hit, xack;
   int fail_count = 0, total_checks = 0, seed = 16, sa, aa, va, xa;
   csq_qualifier DUT (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(ra), .reg_wdata_in(wd),
      .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .port16_in(p16),
      .cycle_start_in(st), .cycle_end_in(en), .cycle_in(cv), .address_strobe_n_in(as_n),
      .data_strobe_n_in(ds_n), .select_n_out(sel_n), .transfer_ack_out(ack),
      .auto_vector_out(av), .e_bus_clock_out(e_bus_clock));
   csq_ext_dev u_dev (.clk_in(clk_in), .reset_in(reset_in), .sel_n_in(sel_n[1]), .clr_in(st),
      .hit_out(hit), .ack_out(xack));
   always #10 clk_in = ~clk_in;
   ////////////////////////////////////////
   task chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
   endtask : wr
   task rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk_in);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask : rd
   // one bus cycle; records the first cycle of select, ack and autovector
   task run(input csq_cycle_t c, input int dd);
      sa = -1;
      aa = -1;
      va = -1;
      xa = -1;
      @(posedge clk_in);
      cv <= c;
      st <= 1'b1;
      as_n <= 1'b0;
      for (int k = 0; k < 24; k++) begin
         @(posedge clk_in);
         st <= 1'b0;
         if (k == dd) ds_n <= 1'b0;
         #1;
         if (sa < 0 && sel_n[1] === 1'b0) sa = k;
         if (aa < 0 && ack === 1'b1) aa = k;
         if (va < 0 && av === 1'b1) va = k;
         if (xa < 0 && xack === 1'b1) xa = k;
      end
      @(posedge clk_in);
      en <= 1'b1;
      as_n <= 1'b1;
      ds_n <= 1'b1;
      @(posedge clk_in);
      en <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask : run
   function automatic logic exp_sel(input logic [15:0] o, input csq_cycle_t c, input logic p);
      logic s, d, b;
      s = o[5:4] == 2'h0 ? c.iack && (o[3:1] == 3'h0 || o[3:1] == c.addr[3:1])
         : !c.iack && c.addr[23:11] == 13'h1340 && (o[5:4] == 2'h3 || o[5:4] == c.fc_space);
      d = o[12:11] == 2'h3 || (o[12:11] == 2'h1 && c.read) || (o[12:11] == 2'h2 && !c.read);
      b = !p || (o[14] && c.upper_byte) || (o[13] && c.lower_byte);
      return s && d && b;
   endfunction : exp_sel
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   initial begin
      #1000000;
      fail_count++;
      wrap_up;
   end
   initial begin
      logic [15:0] o;
      csq_cycle_t c;
      int t;
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(5'h00, rv);
      chk(rv === BOOT_OPT_RESET, "boot option reset");
      for (int i = 1; i < 16; i++) begin
         rd(i[4:0], rv);
         chk(rv === 16'h0000, "option reset or unmapped");
      end
      for (int i = 1; i < 12; i++) begin
         o = 16'($random(seed));
         wr(i[4:0], o);
         rd(i[4:0], rv);
         chk(rv === o, "option readback");
         wr(i[4:0], GEN_OPT_RESET);
      end
      $display("register test done");
      wr(5'h11, 16'h9A00);
      c = '{24'h9A0400, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1};
      wr(5'h01, 16'h7C30);
      run(c, 8);
      chk(sa >= 8 && sa <= 12, "data strobe alignment");
      wr(5'h01, 16'h7830);
      run(c, 8);
      chk(sa >= 1 && sa <= 4, "address strobe alignment");
      wr(5'h01, 16'hF830);
      run(c, 0);
      chk(sa >= 0 && sa <= 9 && aa == -1, "e clock select");
      $display("timing mode test done");
      for (int n = 0; n < 200; n++) begin
         o = 16'($random(seed));
         o[15] = 1'b0;
         c = 30'($random(seed));
         c.addr = n % 4 != 0 ? (24'h9A0000 | (c.addr & 24'h000FFF)) : (c.addr | 24'h800000);
         c.fc_space = c.iack ? 2'h0 : (c.fc_space[0] ? 2'h1 : 2'h2);
         if (!c.upper_byte) c.lower_byte = 1'b1;
         p16 <= NUM_CS'($random(seed));
         wr(5'h01, o);
         run(c, 1);
         chk(hit === exp_sel(o, c, p16[1]), "select qualify");
         t = o[9:6] == 4'hE ? 1 : (o[9:6] == 4'hF ? -1 : o[9:6] + 2);
         if (exp_sel(o, c, p16[1]) && o[5:4] == 2'h0 && o[0])
            chk(va == (t < 0 ? 2 : t) && aa == -1, "autovector timing");
         else
            chk(aa == (exp_sel(o, c, p16[1]) ? t : -1) && va == -1, "ack timing");
         if (exp_sel(o, c, p16[1]) && t < 0)
            chk(xa >= 0, "external acknowledge");
      end
      $display("random qualifier test done");
      wrap_up;
   end
endmodule : tb_csq_qualifier
`default_nettype wire
